// *** bench/mcs_mem_model.sv ***
// Purpose: Shared program memory and ALU seen from the fetch side
// Assumes: Result of an executing fetch in the same cycle as the fetch
// Notes:   Branches only where the bench points it
`timescale 1ns/10ps
module mcs_mem_model import mcs_pkg::*; (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire mcs_fetch_t  fetch,
    input  wire logic [11:0] br_pc,
    input  wire logic [11:0] br_target,
    output mcs_exec_t        exec_out
);
////////////////////////////////////////////////////////////////////////////////
    // The scheduler applies the result while its fetch stands, so answer in that cycle
    always_comb begin
        exec_out.valid  = rst_n && fetch.ex;
        exec_out.branch = (fetch.pc == br_pc);
        exec_out.target = br_target;
    end
endmodule : mcs_mem_model

// *** bench/mcs_sched_tb.sv ***
// Purpose: Self-checking bench for the context scheduler
// Assumes: Boot wait shortened to 8 cycles
// Notes:   Fetch side is sampled on falling edges
`timescale 1ns/10ps
module mcs_sched_tb import mcs_pkg::*; ;
    localparam int BOOT = 8;
    typedef struct {bit w; logic [7:0] a; logic [31:0] d; logic [1:0] r;} mcs_row_t;
    logic        core_clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, irq_evt, io_wr, acc_wr, en_wr;
    logic [7:0]  awaddr, araddr, io_addr, io_wdata, acc_wdata, flag_wdata, en_wdata;
    logic [7:0]  sp_rd, acc_rd, flag_rd;
    logic [31:0] wdata, rdata, v;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    logic [11:0] br_pc, br_target, q;
    logic [2:0]  c, p;
    mcs_exec_t   exec;
    mcs_fetch_t  fetch;
    int          mismatches, checks, n;
    mcs_row_t    rows [6] = '{
        '{0, 8'h04, 32'h1, 2'h0}, '{0, 8'h08, 32'h0, 2'h0},
        '{1, 8'h2c, 32'h33, 2'h0}, '{0, 8'h2c, 32'h33, 2'h0},
        '{1, 8'hf0, 32'h1, 2'h2}, '{0, 8'hf0, 32'h0, 2'h2}};
////////////////////////////////////////////////////////////////////////////////
    mcs_sched #(.BOOT_CYCLES(BOOT)) dut (.core_clk(core_clk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .exec_in(exec), .irq_evt(irq_evt), .io_wr(io_wr), .io_addr(io_addr), .io_wdata(io_wdata),
        .acc_wr(acc_wr), .acc_wdata(acc_wdata), .flag_wdata(flag_wdata), .en_wr(en_wr),
        .en_wdata(en_wdata), .fetch_r(fetch), .sp_rd_r(sp_rd), .acc_rd_r(acc_rd), .flag_rd_r(flag_rd));
    mcs_mem_model mem (.core_clk(core_clk), .rst_n(rst_n), .fetch(fetch), .br_pc(br_pc),
        .br_target(br_target), .exec_out(exec));
////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task conclude;
        if (mismatches == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
        @(posedge core_clk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask : axi_wr
    task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
        @(posedge core_clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata; rs = rresp;
        rready <= 1'b0;
    endtask : axi_rd
    task wait_ctx(input logic [2:0] x);
        do @(negedge core_clk); while (fetch.ctx !== x);
    endtask : wait_ctx
    task pulse_io;
        @(posedge core_clk);
        io_wr <= 1'b1; acc_wr <= 1'b1;
        @(posedge core_clk);
        io_wr <= 1'b0; acc_wr <= 1'b0;
    endtask : pulse_io
    // Long enough for every scenario with a wide margin
    initial begin
        #(20000 * 50);
        mismatches++;
        conclude();
    end
////////////////////////////////////////////////////////////////////////////////
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, irq_evt, io_wr, acc_wr, en_wr} = '0;
        {awaddr, araddr, wdata} = '0; wstrb = 4'hf; io_addr = 8'h02; io_wdata = 8'h44;
        acc_wdata = 8'h5a; flag_wdata = 8'h03; en_wdata = 8'h05; br_pc = 12'h800;
        br_target = 12'hff8; mismatches = 0; checks = 0; rst_n = 1'b0;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) begin
                axi_wr(rows[i].a, rows[i].d, r); chk("bresp", {30'h0, rows[i].r}, r);
            end else begin
                axi_rd(rows[i].a, v, r); chk("rdata", rows[i].d, v);
                chk("rresp", {30'h0, rows[i].r}, r);
            end
        end
        for (int i = 0; i < 8; i++) begin
            @(negedge core_clk); c = fetch.ctx;
            if (i > 0) chk("alternate", p ^ 3'h1, c);
            chk("ex_mode0", c == 3'h0, fetch.ex);
            p = c;
        end
        wait_ctx(0); q = fetch.pc;
        wait_ctx(0); chk("pc_step", q + 12'h1, fetch.pc);
        br_pc <= fetch.pc + 12'h2;
        do wait_ctx(0); while (fetch.pc !== br_pc);
        wait_ctx(0); chk("branch", 12'hff8, fetch.pc);
        br_pc <= 12'h800;
        repeat (8) wait_ctx(0);
        chk("wrap", 12'h000, fetch.pc);
        axi_wr(8'h08, 32'h6, r); chk("mode_resp", 0, r);
        wait_ctx(3);
        @(posedge core_clk); en_wr <= 1'b1;
        @(posedge core_clk); en_wr <= 1'b0;
        wait_ctx(2); chk("pc2_first", 12'h002, fetch.pc);
        wait_ctx(2); chk("pc2_next", 12'h003, fetch.pc);
        for (int i = 0; i < 8; i++) begin
            @(negedge core_clk); c = fetch.ctx;
            if (i > 0) chk("rotate", (p + 3'h1) & 3'h3, c);
            chk("ex_mode6", c == 3'h0 || c == 3'h2, fetch.ex);
            p = c;
        end
        wait_ctx(1); pulse_io();
        wait_ctx(2); chk("sp2", 8'h44, sp_rd);
        chk("acc2", 8'h5a, acc_rd); chk("flag2", 8'h03, flag_rd);
        wait_ctx(0); chk("acc0", 8'h00, acc_rd);
        axi_rd(8'h28, v, r); chk("sp2_reg", 32'h44, v);
        wait_ctx(3);
        @(posedge core_clk); irq_evt <= 1'b1;
        @(posedge core_clk); irq_evt <= 1'b0;
        wait_ctx(2); q = fetch.pc; n = 0;
        do begin wait_ctx(0); n++; end while (fetch.pc !== 12'h010 && n < 3);
        chk("irq_vec", 12'h010, fetch.pc);
        wait_ctx(2); chk("pc2_irq", q + 12'h2, fetch.pc);
        for (int i = 1; i < 8; i++) begin
            if (i == 2) continue;
            axi_wr(8'h10, i, r);
            axi_rd(8'h14, v, r); chk("pc_idle", i, v);
        end
        rst_n <= 1'b0;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        n = 0;
        do begin @(negedge core_clk); n++; end while (fetch.ex !== 1'b1 && n < 100);
        chk("boot", 1, n >= BOOT && n <= BOOT + 4);
        chk("first_fetch", 0, {fetch.ctx, fetch.pc});
        axi_rd(8'h04, v, r); chk("enable_rst", 32'h1, v);
        axi_rd(8'h08, v, r); chk("mode_rst", 32'h0, v);
        conclude();
    end
endmodule : mcs_sched_tb

// *** verilog/mcs_defines.svh ***
// Purpose: Constants for the multi-context scheduler
// Assumes: 20 MHz core clock, AXI4-Lite register access
// Notes:   Offsets are byte addresses
`ifndef MCS_DEFINES_SVH
`define MCS_DEFINES_SVH
`define MCS_NUM_CTX        8
`define MCS_PC_W           12
`define MCS_INT_VEC        12'h010
`define MCS_SYS_LO         12'hff8
`define MCS_DMEM_BYTES     208
`define MCS_OFF_CTRL       8'h00
`define MCS_OFF_SP_IO      8'h02
`define MCS_OFF_ENABLE     8'h04
`define MCS_OFF_MODE       8'h08
`define MCS_OFF_STATUS     8'h0c
`define MCS_OFF_PC_SEL     8'h10
`define MCS_OFF_PC_VAL     8'h14
`define MCS_OFF_SP_BASE    8'h20
`define MCS_ENABLE_RST     8'h01
`define MCS_BOOT_CYCLES    1024
`define MCS_RC_NS          50000
`define MCS_CLK_NS         50
`define MCS_MODE_HALF      3'h0
`define MCS_MODE_QUARTER   3'h6
`endif

// *** verilog/mcs_pkg.sv ***
// Purpose: Types for the multi-context scheduler
// Assumes: mcs_defines.svh included first
// Notes:   Types only
`include "mcs_defines.svh"
package mcs_pkg;
    typedef enum logic [1:0] {MCS_BOOT, MCS_RUN} mcs_state_t;
    typedef struct packed {
        logic        ex;
        logic [2:0]  ctx;
        logic [11:0] pc;
    } mcs_fetch_t;
    typedef struct packed {
        logic        valid;
        logic        branch;
        logic [11:0] target;
    } mcs_exec_t;
endpackage : mcs_pkg

// *** verilog/mcs_sched.sv ***
// Purpose: Slot scheduler and per-context state for eight contexts
// Assumes: AXI4-Lite register bus, one clock, sync active-low reset
// Notes:   Boot wait is a parameter so benches can shorten it
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "mcs_defines.svh"
////////////////////////////////////////////////////////////////////////////////
// Function
// - eight contexts with private PC, SP, ACC, flags
// - shared memories used in exclusive cycles
// - exactly one active context per cycle
// - slots follow mode regardless of enables
// - mode 0 alternates contexts 0 and 1
// - mode 6 rotates contexts 0 to 3
// - per-context enable, only context 0 after reset
// - any context may write enable register
// - PC increments, branches load target
// - PC is 12 bits wide
// - reset loads PC of context n with n
// - interrupt sends only context 0 to 0x10
// - SP at IO 0x02 is executing context's copy
// - reset vectors 0-7, interrupt 0x10, FF8-FFF system
// - wait 1024 low-speed RC cycles before fetch
module mcs_sched import mcs_pkg::*; #(
    parameter int BOOT_CYCLES = `MCS_BOOT_CYCLES * (`MCS_RC_NS / `MCS_CLK_NS)
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire mcs_exec_t   exec_in,
    input  wire logic        irq_evt,
    input  wire logic        io_wr,
    input  wire logic [7:0]  io_addr,
    input  wire logic [7:0]  io_wdata,
    input  wire logic        acc_wr,
    input  wire logic [7:0]  acc_wdata,
    input  wire logic [7:0]  flag_wdata,
    input  wire logic        en_wr,
    input  wire logic [7:0]  en_wdata,
    output mcs_fetch_t       fetch_r,
    output logic [7:0]       sp_rd_r,
    output logic [7:0]       acc_rd_r,
    output logic [7:0]       flag_rd_r
);
    localparam int N = `MCS_NUM_CTX;

    mcs_state_t            state_r;
    logic [31:0]           boot_cnt_r;
    logic [2:0]            slot_r;
    logic [2:0]            mode_r;
    logic [7:0]            enable_r;
    logic [11:0]           pc_r   [N];
    logic [7:0]            sp_r   [N];
    logic [7:0]            acc_r  [N];
    logic [7:0]            flag_r [N];
    logic [2:0]            pc_sel_r;
    logic                  irq_pend_r;
    logic [2:0]            slot_nxt;
    logic                  run;
    logic                  owner_en;
    logic                  ex_cur;
    logic [2:0]            cur;

    // Slot period from the mode: 2 contexts or 4, otherwise all eight
    function automatic logic [2:0] next_slot(input logic [2:0] s, input logic [2:0] m);
        if (m == `MCS_MODE_HALF) begin
            next_slot = {2'b00, ~s[0]};
        end else if (m == `MCS_MODE_QUARTER) begin
            next_slot = {1'b0, s[1:0] + 2'b01};
        end else begin
            next_slot = s + 3'h1;
        end
    endfunction : next_slot

    ////////////////////////////////////////////////////////////////////////////
    // Boot wait and slot rotation
    assign run      = (state_r == MCS_RUN);
    assign slot_nxt = next_slot(slot_r, mode_r);
    assign owner_en = enable_r[slot_r];
    assign cur      = fetch_r.ctx;
    assign ex_cur   = fetch_r.ex;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_r    <= MCS_BOOT;
            boot_cnt_r <= 32'h0;
        end else if (state_r == MCS_BOOT) begin
            boot_cnt_r <= boot_cnt_r + 32'h1;
            if (boot_cnt_r >= BOOT_CYCLES - 1) begin
                state_r <= MCS_RUN;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            slot_r <= 3'h0;
        end else if (run) begin
            slot_r <= slot_nxt;
        end
    end

    // Grant: one context per cycle, fetch only if enabled
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            fetch_r <= '0;
        end else begin
            fetch_r.ctx <= slot_r;
            fetch_r.ex  <= run && owner_en;
            fetch_r.pc  <= pc_r[slot_r];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-context program counters
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < N; i++) begin
                pc_r[i] <= 12'(i);
            end
        end else if (ex_cur) begin
            if (cur == 3'h0 && irq_pend_r) begin
                pc_r[0] <= `MCS_INT_VEC;
            end else if (exec_in.valid && exec_in.branch) begin
                pc_r[cur] <= exec_in.target;
            end else if (exec_in.valid) begin
                pc_r[cur] <= pc_r[cur] + 12'h001;
            end
        end
    end

    // Interrupt held until context 0 executes in its slot; set wins over clear
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irq_pend_r <= 1'b0;
        end else if (irq_evt) begin
            irq_pend_r <= 1'b1;
        end else if (ex_cur && cur == 3'h0) begin
            irq_pend_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Private stack pointer, accumulator and flags
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < N; i++) begin
                sp_r[i]   <= 8'h00;
                acc_r[i]  <= 8'h00;
                flag_r[i] <= 8'h00;
            end
        end else begin
            // Software may preset any context's stack; the executing context's own write wins
            if (do_wr && w_strb_r[0] && aw_addr_r[7:5] == 3'h1) begin
                sp_r[aw_addr_r[4:2]] <= w_data_r[7:0];
            end
            if (ex_cur) begin
                if (io_wr && io_addr == `MCS_OFF_SP_IO) begin
                    sp_r[cur] <= io_wdata;
                end
                if (acc_wr) begin
                    acc_r[cur]  <= acc_wdata;
                    flag_r[cur] <= flag_wdata;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sp_rd_r   <= 8'h00;
            acc_rd_r  <= 8'h00;
            flag_rd_r <= 8'h00;
        end else begin
            sp_rd_r   <= sp_r[slot_r];
            acc_rd_r  <= acc_r[slot_r];
            flag_rd_r <= flag_r[slot_r];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave: write path
    logic       aw_ok_r;
    logic       w_ok_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic       do_wr;

    assign do_wr = aw_ok_r && w_ok_r && !s_axi_bvalid;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            aw_ok_r       <= 1'b0;
            w_ok_r        <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            aw_addr_r     <= 8'h00;
            w_data_r      <= 32'h0;
            w_strb_r      <= 4'h0;
        end else begin
            s_axi_awready <= !aw_ok_r && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_ok_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok_r   <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok_r   <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_ok_r      <= 1'b0;
                w_ok_r       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_r == `MCS_OFF_ENABLE || aw_addr_r == `MCS_OFF_MODE ||
                                 aw_addr_r == `MCS_OFF_PC_SEL ||
                                 aw_addr_r[7:5] == 3'h1) ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Enable and mode registers; a running context's write wins over software
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            enable_r <= `MCS_ENABLE_RST;
            mode_r   <= `MCS_MODE_HALF;
            pc_sel_r <= 3'h0;
        end else begin
            if (do_wr && w_strb_r[0]) begin
                if (aw_addr_r == `MCS_OFF_ENABLE) enable_r <= w_data_r[7:0];
                if (aw_addr_r == `MCS_OFF_MODE)   mode_r   <= w_data_r[2:0];
                if (aw_addr_r == `MCS_OFF_PC_SEL) pc_sel_r <= w_data_r[2:0];
            end
            if (ex_cur && en_wr) begin
                enable_r <= en_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave: read path
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        unique case (s_axi_araddr)
            `MCS_OFF_ENABLE: rd_mux = {24'h0, enable_r};
            `MCS_OFF_MODE:   rd_mux = {29'h0, mode_r};
            `MCS_OFF_STATUS: rd_mux = {23'h0, irq_pend_r, run, fetch_r.ex, 2'b00, slot_r, 1'b0};
            `MCS_OFF_PC_SEL: rd_mux = {29'h0, pc_sel_r};
            `MCS_OFF_PC_VAL: rd_mux = {20'h0, pc_r[pc_sel_r]};
            default: begin
                if (s_axi_araddr[7:5] == 3'h1) rd_mux = {24'h0, sp_r[s_axi_araddr[4:2]]};
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= (s_axi_araddr inside {`MCS_OFF_ENABLE, `MCS_OFF_MODE, `MCS_OFF_STATUS,
                                 `MCS_OFF_PC_SEL, `MCS_OFF_PC_VAL} || s_axi_araddr[7:5] == 3'h1)
                                ? 2'h0 : 2'h2;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_one_ctx_mode0;
        @(posedge core_clk) disable iff (!rst_n)
        (run && mode_r == 3'h0 && $stable(mode_r)) |=> (slot_r != $past(slot_r) && slot_r[2:1] == 2'b00);
    endproperty
    a_one_ctx_mode0: assert property (p_one_ctx_mode0) else $error("mode 0 slot not alternating");
    property p_mode6;
        @(posedge core_clk) disable iff (!rst_n)
        (run && mode_r == 3'h6 && $stable(mode_r)) |=> (slot_r[2] == 1'b0 && slot_r == (($past(slot_r) + 3'h1) & 3'h3));
    endproperty
    a_mode6: assert property (p_mode6) else $error("mode 6 rotation broken");
    property p_no_ex_disabled;
        @(posedge core_clk) disable iff (!rst_n) fetch_r.ex |-> $past(enable_r[slot_r]);
    endproperty
    a_no_ex_disabled: assert property (p_no_ex_disabled) else $error("disabled context executed");
    property p_boot;
        @(posedge core_clk) disable iff (!rst_n) !run |=> !fetch_r.ex;
    endproperty
    a_boot: assert property (p_boot) else $error("fetch during boot");
    property p_irq;
        @(posedge core_clk) disable iff (!rst_n)
        (ex_cur && cur == 3'h0 && irq_pend_r) |=> pc_r[0] == 12'h010;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt vector wrong");
    property p_inc;
        @(posedge core_clk) disable iff (!rst_n)
        (ex_cur && exec_in.valid && !exec_in.branch && !(cur == 3'h0 && irq_pend_r))
        |=> pc_r[$past(cur)] == $past(pc_r[cur]) + 12'h001;
    endproperty
    a_inc: assert property (p_inc) else $error("pc not incremented");
    property p_reset_pc;
        @(posedge core_clk) $fell(rst_n) ##1 !rst_n |-> pc_r[7] == 12'h007 && pc_r[1] == 12'h001;
    endproperty
    a_reset_pc: assert property (p_reset_pc) else $error("reset vector wrong");
    property p_en_reset;
        @(posedge core_clk) !rst_n |=> enable_r == 8'h01;
    endproperty
    a_en_reset: assert property (p_en_reset) else $error("enable reset wrong");
    c_irq: cover property (@(posedge core_clk) ex_cur && cur == 3'h0 && irq_pend_r);
    c_mode6: cover property (@(posedge core_clk) run && mode_r == 3'h6 && slot_r == 3'h3);
    c_skip: cover property (@(posedge core_clk) run && !owner_en);
endmodule : mcs_sched
